// *** pkg/cpm_pkg.sv ***
package cpm_pkg;

    // Register bus request, one cycle per access
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cpm_req_t;

    // Clock source codes shared by the main and output selectors
    typedef enum logic [2:0] {
        SRC_FRO     = 3'h0,
        SRC_FRO_DIV = 3'h1,
        SRC_LPOSC   = 3'h2,
        SRC_PIN     = 3'h3,
        SRC_MAIN    = 3'h4,
        SRC_NONE    = 3'h7
    } cpm_src_t;

    // Power state of the chip
    typedef enum logic [1:0] {
        PM_RUN   = 2'h0,
        PM_SLEEP = 2'h1,
        PM_DEEP  = 2'h2,
        PM_PDOWN = 2'h3
    } cpm_pm_t;

    // Register byte offsets
    localparam logic [7:0] OFS_FRO_CTRL   = 8'h00;
    localparam logic [7:0] OFS_MAIN_SEL   = 8'h04;
    localparam logic [7:0] OFS_CLOCK_OUTPUT_FUNCTION_SEL = 8'h08;
    localparam logic [7:0] OFS_SWITCH_MTX = 8'h0C;
    localparam logic [7:0] OFS_PERIPH_GATE = 8'h10;
    localparam logic [7:0] OFS_CPU_DIV    = 8'h14;
    localparam logic [7:0] OFS_RUN_PWR    = 8'h18;
    localparam logic [7:0] OFS_SLEEP_PWR  = 8'h1C;
    localparam logic [7:0] OFS_PMODE      = 8'h20;
    localparam logic [7:0] OFS_WAKE_EN    = 8'h24;
    localparam logic [7:0] OFS_STATUS     = 8'h28;

    // Field positions
    localparam int RUN_FRO_PD_BIT   = 0;
    localparam int RUN_FROOUT_PD_BIT = 1;
    localparam int RUN_LPOSC_PD_BIT = 2;
    localparam int RUN_BOD_PD_BIT   = 3;
    localparam int SLP_LPOSC_BIT    = 0;
    localparam int SLP_BOD_BIT      = 1;
    localparam int SWM_PIN_CLOCK_INPUT_EN_BIT = 3;
    localparam int SWM_CLOCK_OUTPUT_FUNCTION_EN_BIT = 11;

    // FRO frequency codes
    localparam logic [1:0] FRO_SEL_9  = 2'h0;
    localparam logic [1:0] FRO_SEL_12 = 2'h1;
    localparam logic [1:0] FRO_SEL_15 = 2'h2;

    // Values after reset
    localparam logic [1:0]  RST_FRO_SEL  = FRO_SEL_12;
    localparam logic [3:0]  RST_RUN_PWR  = 4'h4;
    localparam logic [7:0]  RST_CPU_DIV  = 8'h01;

    // Rates, in kHz
    localparam int MCLK_KHZ   = 200000;
    localparam int FRO9_KHZ   = 9000;
    localparam int FRO12_KHZ  = 12000;
    localparam int FRO15_KHZ  = 15000;
    localparam int LPOSC_KHZ  = 1000;
    localparam int ACC_W      = 19;

endpackage : cpm_pkg

// *** rtl/cpm_ctrl.sv ***
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cpm_ctrl
    import cpm_pkg::*;
#(
    parameter int NPERIPH = 16,
    parameter int NWAKE   = 8,
    parameter int NPINS   = 8
)(
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               resetn,
    // Register port
    input  wire cpm_req_t           req,
    output logic [31:0]             rd_data_q,
    // Core side
    input  wire logic               sleep_req,
    input  wire logic               any_irq,
    input  wire logic [NWAKE-1:0]   wake_irq,
    input  wire logic [NWAKE-1:0]   irq_enabled,
    output logic                    core_clk_en_q,
    output logic                    ahb_clk_en_q,
    output logic                    main_clk_q,
    output logic [NPERIPH-1:0]      periph_clk_en_q,
    output logic [1:0]              pm_state_q,
    // Oscillator, analog and flash power
    output logic                    fro_on_q,
    output logic                    fro_out_on_q,
    output logic                    lposc_on_q,
    output logic                    bod_on_q,
    output logic                    analog_on_q,
    output logic                    flash_standby_q,
    output logic                    flash_off_q,
    // Pins through the switch matrix
    input  wire logic [NPINS-1:0]   pin_in,
    output logic [NPINS-1:0]        pin_out_q,
    output logic [NPINS-1:0]        pin_oe_q
);

    // Refuse sizes that the register map and pin select cannot serve
    if (NPERIPH < 1 || NPERIPH > 32 || NWAKE < 1 || NWAKE > 32
        || NPINS != 8)
    begin : g_bad_params
        $error("cpm_ctrl: unsupported parameter values");
    end

    // Phase accumulator step: a pulse marks one half period
    function automatic logic [ACC_W:0] acc_step(input logic [ACC_W-1:0] acc,
                                                input int khz);
        logic [ACC_W:0] s;
        s = {1'b0, acc} + ACC_W'(2 * khz);
        if (s >= (ACC_W+1)'(MCLK_KHZ))
            acc_step = {1'b1, ACC_W'(s - (ACC_W+1)'(MCLK_KHZ))};
        else
            acc_step = {1'b0, s[ACC_W-1:0]};
    endfunction : acc_step

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [1:0]          fro_sel_q;
    cpm_src_t            main_req_q;
    cpm_src_t            clock_output_function_sel_q;
    logic [11:0]         swm_q;
    logic [NPERIPH-1:0]  gate_q;
    logic [7:0]          cpu_div_q;
    logic [3:0]          run_pwr_q;
    logic [1:0]          sleep_pwr_q;
    logic [1:0]          pmode_q;
    logic [NWAKE-1:0]    wake_en_q;
    cpm_src_t            main_sel_q;
    logic                sw_hold_q;
    cpm_pm_t             pm_q;

    // Software writes; main and output selectors reset to FRO and none
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            fro_sel_q    <= RST_FRO_SEL;
            main_req_q   <= SRC_FRO;
            clock_output_function_sel_q <= SRC_NONE;
            swm_q        <= 12'h000;
            gate_q       <= '0;
            cpu_div_q    <= RST_CPU_DIV;
            run_pwr_q    <= RST_RUN_PWR;
            sleep_pwr_q  <= 2'h0;
            pmode_q      <= 2'h0;
            wake_en_q    <= '0;
        end
        else if (req.wr)
        begin
            case (req.addr)
                OFS_FRO_CTRL:    fro_sel_q    <= req.wdata[1:0];
                OFS_MAIN_SEL:    main_req_q   <= cpm_src_t'(req.wdata[2:0]);
                OFS_CLOCK_OUTPUT_FUNCTION_SEL:  clock_output_function_sel_q <= cpm_src_t'(req.wdata[2:0]);
                OFS_SWITCH_MTX:  swm_q        <= req.wdata[11:0];
                OFS_PERIPH_GATE: gate_q       <= req.wdata[NPERIPH-1:0];
                OFS_CPU_DIV:     cpu_div_q    <= req.wdata[7:0];
                OFS_RUN_PWR:     run_pwr_q    <= req.wdata[3:0];
                OFS_SLEEP_PWR:   sleep_pwr_q  <= req.wdata[1:0];
                OFS_PMODE:       pmode_q      <= req.wdata[1:0];
                OFS_WAKE_EN:     wake_en_q    <= req.wdata[NWAKE-1:0];
                default:         ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rd_data_q <= 32'h0000_0000;
        else if (req.rd)
        begin
            case (req.addr)
                OFS_FRO_CTRL:    rd_data_q <= {30'h0, fro_sel_q};
                OFS_MAIN_SEL:    rd_data_q <= {29'h0, main_req_q};
                OFS_CLOCK_OUTPUT_FUNCTION_SEL:  rd_data_q <= {29'h0, clock_output_function_sel_q};
                OFS_SWITCH_MTX:  rd_data_q <= {20'h0, swm_q};
                OFS_PERIPH_GATE: rd_data_q <= 32'(gate_q);
                OFS_CPU_DIV:     rd_data_q <= {24'h0, cpu_div_q};
                OFS_RUN_PWR:     rd_data_q <= {28'h0, run_pwr_q};
                OFS_SLEEP_PWR:   rd_data_q <= {30'h0, sleep_pwr_q};
                OFS_PMODE:       rd_data_q <= {30'h0, pmode_q};
                OFS_WAKE_EN:     rd_data_q <= 32'(wake_en_q);
                OFS_STATUS:      rd_data_q <= {25'h0, main_clk_q, sw_hold_q,
                                               main_sel_q, pm_q};
                default:         rd_data_q <= 32'h0000_0000;
            endcase
        end
        else
            rd_data_q <= 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator models as half-period pulses
    logic [ACC_W-1:0] fro_acc_q, div_acc_q, lp_acc_q;
    logic             fro_p_q, div_p_q, lp_p_q;
    logic [ACC_W:0]   fro_n, div_n, lp_n;
    int               fro_khz;

    always_comb
    begin
        case (fro_sel_q)
            FRO_SEL_9:  fro_khz = FRO9_KHZ;
            FRO_SEL_15: fro_khz = FRO15_KHZ;
            default:    fro_khz = FRO12_KHZ;
        endcase
        fro_n = acc_step(fro_acc_q, fro_khz);
        div_n = acc_step(div_acc_q, fro_khz / 2);
        lp_n  = acc_step(lp_acc_q, LPOSC_KHZ);
    end

    // Free-running pulse generators, held off while powered down
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            fro_acc_q <= '0;
            div_acc_q <= '0;
            lp_acc_q  <= '0;
            fro_p_q   <= 1'b0;
            div_p_q   <= 1'b0;
            lp_p_q    <= 1'b0;
        end
        else
        begin
            fro_acc_q <= fro_n[ACC_W-1:0];
            div_acc_q <= div_n[ACC_W-1:0];
            lp_acc_q  <= lp_n[ACC_W-1:0];
            fro_p_q   <= fro_n[ACC_W] & fro_on_q & fro_out_on_q;
            div_p_q   <= div_n[ACC_W] & fro_on_q & fro_out_on_q;
            lp_p_q    <= lp_n[ACC_W] & lposc_on_q;
        end
    end

    // Pin clock: two-flop synchroniser, then both-edge detect
    logic [NPINS-1:0] pin_s1_q, pin_s2_q;
    logic             pin_prev_q, pin_p_q, pin_lvl;

    assign pin_lvl = pin_s2_q[swm_q[2:0]];

    // Other party keeps this clock at or below 15 MHz, so edges stay apart
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_s1_q   <= '0;
            pin_s2_q   <= '0;
            pin_prev_q <= 1'b0;
            pin_p_q    <= 1'b0;
        end
        else
        begin
            pin_s1_q   <= pin_in;
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_lvl;
            pin_p_q    <= (pin_lvl ^ pin_prev_q)
                          & swm_q[SWM_PIN_CLOCK_INPUT_EN_BIT];
        end
    end

    // Source pulse by code; none never pulses
    function automatic logic src_pulse(input cpm_src_t s, input logic mn);
        case (s)
            SRC_FRO:     src_pulse = fro_p_q;
            SRC_FRO_DIV: src_pulse = div_p_q;
            SRC_LPOSC:   src_pulse = lp_p_q;
            SRC_PIN:     src_pulse = pin_p_q;
            SRC_MAIN:    src_pulse = mn;
            default:     src_pulse = 1'b0;
        endcase
    endfunction : src_pulse

    ////////////////////////////////////////////////////////////////////////
    // Glitch-free main selector: a switch is committed only at a falling
    // edge of the old source, then the clock is parked low until the new
    // source pulses, so both phases only ever stretch. Limitation: a
    // source that dies while selected freezes the clock until it returns.
    logic cur_p, new_p, main_rise;

    // A process, since only a process follows what the function reads
    always_comb
    begin
        cur_p     = src_pulse(main_sel_q, 1'b0);
        new_p     = src_pulse(main_req_q, 1'b0);
        main_rise = cur_p & ~main_clk_q & ~sw_hold_q;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            main_sel_q <= SRC_FRO;
            main_clk_q <= 1'b0;
            sw_hold_q  <= 1'b0;
        end
        else if (!sw_hold_q)
        begin
            if (main_sel_q == SRC_NONE && main_req_q != SRC_NONE)
                sw_hold_q <= 1'b1;
            else if (cur_p)
            begin
                main_clk_q <= ~main_clk_q;
                if (main_clk_q && main_req_q != main_sel_q)
                    sw_hold_q <= 1'b1;
            end
        end
        else if (new_p || main_req_q == SRC_NONE)
        begin
            main_sel_q <= main_req_q;
            sw_hold_q  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state sequencer
    logic wake_hit;

    assign wake_hit = |(wake_irq & wake_en_q & irq_enabled);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            pm_q <= PM_RUN;
        else
        begin
            case (pm_q)
                PM_RUN:
                    if (sleep_req)
                    begin
                        case (pmode_q)
                            2'h1:    pm_q <= PM_DEEP;
                            2'h2:    pm_q <= PM_PDOWN;
                            default: pm_q <= PM_SLEEP;
                        endcase
                    end
                PM_SLEEP:
                    if (any_irq)
                        pm_q <= PM_RUN;
                PM_DEEP:
                    if (wake_hit)
                        pm_q <= PM_RUN;
                PM_PDOWN:
                    if (wake_hit)
                        pm_q <= PM_RUN;
                default: pm_q <= PM_RUN;
            endcase
        end
    end

    // Oscillator, analog and flash power per state
    logic fro_main, lp_main;

    assign fro_main = (main_sel_q == SRC_FRO) || (main_sel_q == SRC_FRO_DIV);
    assign lp_main  = (main_sel_q == SRC_LPOSC);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            fro_on_q        <= 1'b1;
            fro_out_on_q    <= 1'b1;
            lposc_on_q      <= 1'b0;
            bod_on_q        <= 1'b1;
            analog_on_q     <= 1'b1;
            flash_standby_q <= 1'b0;
            flash_off_q     <= 1'b0;
        end
        else
        begin
            case (pm_q)
                PM_DEEP:
                begin
                    fro_on_q        <= fro_main;
                    fro_out_on_q    <= 1'b0;
                    lposc_on_q      <= ~run_pwr_q[RUN_LPOSC_PD_BIT]
                                       & (lp_main
                                          | sleep_pwr_q[SLP_LPOSC_BIT]);
                    bod_on_q        <= sleep_pwr_q[SLP_BOD_BIT];
                    analog_on_q     <= 1'b0;
                    flash_standby_q <= 1'b1;
                    flash_off_q     <= 1'b0;
                end
                PM_PDOWN:
                begin
                    fro_on_q        <= 1'b0;
                    fro_out_on_q    <= 1'b0;
                    lposc_on_q      <= ~run_pwr_q[RUN_LPOSC_PD_BIT]
                                       & (lp_main
                                          | sleep_pwr_q[SLP_LPOSC_BIT]);
                    bod_on_q        <= sleep_pwr_q[SLP_BOD_BIT];
                    analog_on_q     <= 1'b0;
                    flash_standby_q <= 1'b0;
                    flash_off_q     <= 1'b1;
                end
                default:
                begin
                    fro_on_q        <= ~run_pwr_q[RUN_FRO_PD_BIT];
                    fro_out_on_q    <= ~run_pwr_q[RUN_FROOUT_PD_BIT];
                    lposc_on_q      <= ~run_pwr_q[RUN_LPOSC_PD_BIT];
                    bod_on_q        <= ~run_pwr_q[RUN_BOD_PD_BIT];
                    analog_on_q     <= 1'b1;
                    flash_standby_q <= 1'b0;
                    flash_off_q     <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core and AHB enable every cpu_div main rises; zero acts as one
    logic [7:0] div_cnt_q;
    logic       div_hit;

    assign div_hit = main_rise
                     && (div_cnt_q + 8'h01 >= cpu_div_q || cpu_div_q == 8'h00);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_cnt_q     <= 8'h00;
            core_clk_en_q <= 1'b0;
            ahb_clk_en_q  <= 1'b0;
        end
        else
        begin
            if (main_rise)
                div_cnt_q <= div_hit ? 8'h00 : div_cnt_q + 8'h01;
            core_clk_en_q <= div_hit && pm_q == PM_RUN;
            ahb_clk_en_q  <= div_hit && pm_q == PM_RUN;
        end
    end

    // Peripheral enables run in run and sleep, stop in deeper modes
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            periph_clk_en_q <= '0;
        else if (pm_q == PM_RUN || pm_q == PM_SLEEP)
            periph_clk_en_q <= gate_q & {NPERIPH{main_rise}};
        else
            periph_clk_en_q <= '0;
    end

    assign pm_state_q = pm_q;

    ////////////////////////////////////////////////////////////////////////
    // Clock output: any source or main clock, driven on one chosen pin
    logic clock_output_function_q;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            clock_output_function_q  <= 1'b0;
            pin_out_q <= '0;
            pin_oe_q  <= '0;
        end
        else
        begin
            if (clock_output_function_sel_q == SRC_MAIN)
                clock_output_function_q <= main_clk_q;
            else if (clock_output_function_sel_q == SRC_NONE)
                clock_output_function_q <= 1'b0;
            else if (src_pulse(clock_output_function_sel_q, 1'b0))
                clock_output_function_q <= ~clock_output_function_q;
            pin_oe_q  <= swm_q[SWM_CLOCK_OUTPUT_FUNCTION_EN_BIT]
                         ? NPINS'(1) << swm_q[10:8] : '0;
            pin_out_q <= {NPINS{clock_output_function_q}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_switch_only_held: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(main_sel_q) |-> $past(sw_hold_q))
        else $error("main source changed without hold");
    a_hold_parks_low: assert property (@(posedge mclk) disable iff (!resetn)
        sw_hold_q |-> !main_clk_q)
        else $error("main clock high during switch");
    a_lposc_gated: assert property (@(posedge mclk) disable iff (!resetn)
        lp_p_q |-> $past(lposc_on_q))
        else $error("low-power clock without enable");
    a_pin_clk_gated: assert property (@(posedge mclk) disable iff (!resetn)
        pin_p_q |-> $past(swm_q[SWM_PIN_CLOCK_INPUT_EN_BIT]))
        else $error("pin clock not assigned");
    a_core_stops: assert property (@(posedge mclk) disable iff (!resetn)
        pm_q != PM_RUN ##1 pm_q != PM_RUN |-> !core_clk_en_q)
        else $error("core clock runs in sleep");
    a_sleep_periph: assert property (@(posedge mclk) disable iff (!resetn)
        pm_q == PM_SLEEP && main_rise && gate_q[0]
        |=> periph_clk_en_q[0])
        else $error("peripheral clock stopped in sleep");
    a_deep_periph: assert property (@(posedge mclk) disable iff (!resetn)
        pm_q == PM_DEEP |=> periph_clk_en_q == '0 && !fro_out_on_q)
        else $error("clocks alive in deep sleep");
    a_pdown_fro_off: assert property (@(posedge mclk) disable iff (!resetn)
        pm_q == PM_PDOWN |=> !fro_on_q && flash_off_q)
        else $error("fro or flash on in power-down");
    a_deep_wake: assert property (@(posedge mclk) disable iff (!resetn)
        (pm_q == PM_DEEP || pm_q == PM_PDOWN) && wake_hit
        |=> pm_q == PM_RUN)
        else $error("missed wake-up");
    a_wake_needs_en: assert property (@(posedge mclk) disable iff (!resetn)
        pm_q == PM_PDOWN && !wake_hit |=> pm_q == PM_PDOWN)
        else $error("woke without enabled source");

    c_switch_done: cover property (@(posedge mclk) disable iff (!resetn)
        sw_hold_q ##1 !sw_hold_q);
    c_deep_round: cover property (@(posedge mclk) disable iff (!resetn)
        pm_q == PM_DEEP ##1 pm_q == PM_RUN);
    c_sleep_wake: cover property (@(posedge mclk) disable iff (!resetn)
        pm_q == PM_SLEEP ##1 pm_q == PM_RUN);

endmodule : cpm_ctrl

// *** tb/clock_source_and_power_mode_ctrl_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
    fail_count++; $display("BAD %0t got %0h want %0h", $time, a, b); \
    end end
module clock_source_and_power_mode_ctrl_bench;
    import cpm_pkg::*;
    logic mclk = 1'b0, resetn = 1'b0;
    cpm_req_t req = '0;
    logic [31:0] rd_data_q, d;
    logic sleep_req, any_irq, core_clk_en_q, ahb_clk_en_q, main_clk_q;
    logic [7:0] wake_irq, irq_enabled, pin_out_q, pin_oe_q, pin_in;
    logic op;
    logic [15:0] periph_clk_en_q;
    logic [1:0] pm_state_q;
    logic fro_on_q, fro_out_on_q, lposc_on_q, bod_on_q, analog_on_q;
    logic flash_standby_q, flash_off_q;
    int fail_count = 0, n_checks = 0, pc, cc, c12, ac, oc;
    ////////////////////////////////////////////////////////////////////
    always #2.5 mclk = ~mclk;
    cpm_core_model cpm_core_model_inst (.mclk(mclk), .sleep_req(sleep_req),
        .any_irq(any_irq), .wake_irq(wake_irq), .irq_enabled(irq_enabled),
        .pin_clk(pin_in));
    cpm_ctrl cpm_ctrl_inst (.mclk(mclk), .resetn(resetn), .req(req),
        .rd_data_q(rd_data_q), .sleep_req(sleep_req), .any_irq(any_irq),
        .wake_irq(wake_irq), .irq_enabled(irq_enabled),
        .core_clk_en_q(core_clk_en_q), .ahb_clk_en_q(ahb_clk_en_q),
        .main_clk_q(main_clk_q), .periph_clk_en_q(periph_clk_en_q),
        .pm_state_q(pm_state_q), .fro_on_q(fro_on_q),
        .fro_out_on_q(fro_out_on_q), .lposc_on_q(lposc_on_q),
        .bod_on_q(bod_on_q), .analog_on_q(analog_on_q),
        .flash_standby_q(flash_standby_q), .flash_off_q(flash_off_q),
        .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q));
    ////////////////////////////////////////////////////////////////////
    // Register bus, one strobe cycle each
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req <= '0;
        #1 d = rd_data_q;
    endtask : rd
    // Bounded wait for a power state; a miss ends the run
    task automatic wait_state(input logic [1:0] s);
        for (int i = 0; i < 20 && pm_state_q !== s; i++) @(posedge mclk);
        `CHK(pm_state_q, s)
        if (pm_state_q !== s) summarize();
        repeat (3) @(posedge mclk);
    endtask : wait_state
    // Pulses of peripheral 0 and of the core over 200 cycles
    task automatic cnt;
        pc = 0;
        cc = 0;
        ac = 0;
        oc = 0;
        op = pin_out_q[2];
        repeat (200)
        begin
            @(posedge mclk);
            #1 pc += periph_clk_en_q[0];
            cc += core_clk_en_q;
            ac += ahb_clk_en_q;
            oc += (pin_out_q[2] !== op);
            op = pin_out_q[2];
        end
    endtask : cnt
    task automatic summarize;
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(OFS_STATUS); `CHK(d[4:0], {SRC_FRO, PM_RUN})
        rd(OFS_FRO_CTRL); `CHK(d, 32'h1)
        rd(OFS_RUN_PWR); `CHK(d, 32'h4)
        `CHK(lposc_on_q, 1'b0)
        rd(OFS_CPU_DIV); `CHK(d, 32'h1)
        rd(8'hFC); `CHK(d, 32'h0)
        wr(OFS_PERIPH_GATE, 32'h1);
        cnt(); c12 = cc;
        `CHK(pc > 0 && cc > 0, 1'b1)
        `CHK(c12 >= 11 && c12 <= 13, 1'b1)
        wr(OFS_FRO_CTRL, 32'h2);
        cnt(); `CHK(cc > c12, 1'b1)
        wr(OFS_FRO_CTRL, 32'h0);
        cnt(); `CHK(cc >= 8 && cc <= 10, 1'b1)
        wr(OFS_FRO_CTRL, 32'h1);
    endtask : t_reset
    task automatic t_modes;
        wr(OFS_PMODE, 32'h0); cpm_core_model_inst.sleep();
        wait_state(PM_SLEEP); cnt();
        `CHK({cc == 0, pc > 0}, 2'b11)
        cpm_core_model_inst.raise(1'b1, 8'h00, 8'h00);
        wait_state(PM_RUN);
        cpm_core_model_inst.raise(1'b0, 8'h00, 8'h00);
        wr(OFS_WAKE_EN, 32'h1); wr(OFS_PMODE, 32'h1);
        cpm_core_model_inst.sleep(); wait_state(PM_DEEP); cnt();
        `CHK({fro_out_on_q, pc == 0}, 2'b01)
        `CHK({analog_on_q, flash_standby_q}, 2'b01)
        `CHK({bod_on_q, fro_on_q}, 2'b01)
        cpm_core_model_inst.raise(1'b0, 8'h01, 8'h00);
        repeat (20) @(posedge mclk);
        `CHK(pm_state_q, PM_DEEP)
        cpm_core_model_inst.raise(1'b0, 8'h01, 8'h01);
        wait_state(PM_RUN);
        wr(OFS_SLEEP_PWR, 32'h2);
        wr(OFS_PMODE, 32'h2); cpm_core_model_inst.raise(1'b0, 8'h02, 8'h02);
        cpm_core_model_inst.sleep(); wait_state(PM_PDOWN);
        `CHK({fro_on_q, flash_off_q}, 2'b01)
        `CHK(bod_on_q, 1'b1)
        `CHK(pm_state_q, PM_PDOWN)
        cpm_core_model_inst.raise(1'b0, 8'h01, 8'h01);
        wait_state(PM_RUN);
        cpm_core_model_inst.raise(1'b0, 8'h00, 8'h00);
    endtask : t_modes
    // Main source walk: unassigned pin, pin, FRO/2, LPOSC, none, FRO
    task automatic t_misc;
        wr(OFS_MAIN_SEL, 32'h3); repeat (50) @(posedge mclk);
        rd(OFS_STATUS); `CHK(d[5:2], {1'b1, SRC_FRO})
        wr(OFS_SWITCH_MTX, 32'h9); repeat (20) @(posedge mclk);
        cnt(); `CHK(cc >= 12 && cc <= 13, 1'b1)
        rd(OFS_STATUS); `CHK(d[5:2], {1'b0, SRC_PIN})
        wr(OFS_MAIN_SEL, 32'h1); repeat (50) @(posedge mclk);
        cnt(); `CHK(cc >= 5 && cc <= 7, 1'b1)
        rd(OFS_STATUS); `CHK(d[5:2], {1'b0, SRC_FRO_DIV})
        wr(OFS_MAIN_SEL, 32'h2); repeat (150) @(posedge mclk);
        rd(OFS_STATUS); `CHK(d[5:2], {1'b1, SRC_FRO_DIV})
        wr(OFS_RUN_PWR, 32'h0); repeat (150) @(posedge mclk);
        `CHK(lposc_on_q, 1'b1)
        rd(OFS_STATUS); `CHK(d[5:2], {1'b0, SRC_LPOSC})
        wr(OFS_MAIN_SEL, 32'h7); repeat (250) @(posedge mclk);
        cnt(); `CHK({cc == 0, main_clk_q}, 2'b10)
        rd(OFS_STATUS); `CHK(d[5:2], {1'b0, SRC_NONE})
        wr(OFS_MAIN_SEL, 32'h0); repeat (20) @(posedge mclk);
        wr(OFS_CLOCK_OUTPUT_FUNCTION_SEL, 32'h4); wr(OFS_SWITCH_MTX, 32'hA00);
        repeat (3) @(posedge mclk);
        `CHK(pin_oe_q, 8'h04)
        cnt(); `CHK(oc >= 23 && oc <= 25, 1'b1)
        `CHK(ac, cc)
    endtask : t_misc
    // Reset in mid-run brings back FRO at 12 MHz
    task automatic t_rerun;
        wr(OFS_MAIN_SEL, 32'h1); repeat (50) @(posedge mclk);
        resetn <= 1'b0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        rd(OFS_MAIN_SEL); `CHK(d, 32'h0)
        rd(OFS_STATUS); `CHK(d[4:2], SRC_FRO)
        cnt(); `CHK(cc >= 11 && cc <= 13, 1'b1)
    endtask : t_rerun
    // Main sequence
    initial
    begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_modes();
        t_misc();
        t_rerun();
        summarize();
    end
endmodule : clock_source_and_power_mode_ctrl_bench

// *** tb/cpm_core_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Core side: wait-for-interrupt pulses and interrupt levels
module cpm_core_model
    import cpm_pkg::*;
(
    // Clock
    input  wire logic       mclk,
    // Requests to the block
    output logic            sleep_req,
    output logic            any_irq,
    output logic [7:0]      wake_irq,
    output logic [7:0]      irq_enabled,
    // External clock on pin 1, other pins low
    output logic [7:0]      pin_clk
);
    logic [3:0] pin_div = 4'h0;
    // Toggles every 8 cycles: 12.5 MHz, inside the 15 MHz limit
    always @(posedge mclk)
        pin_div <= pin_div + 4'h1;
    assign pin_clk = {6'h00, pin_div[3], 1'b0};
    // Quiet until the bench asks for something
    initial
    begin
        sleep_req = 1'b0;
        any_irq = 1'b0;
        wake_irq = 8'h00;
        irq_enabled = 8'h00;
    end
    // One-cycle pulse, as the core gives on wait-for-interrupt
    task automatic sleep;
        @(posedge mclk);
        sleep_req <= 1'b1;
        @(posedge mclk);
        sleep_req <= 1'b0;
    endtask : sleep
    // Interrupt controller enables travel beside the lines
    task automatic raise(input logic i, input logic [7:0] w,
                         input logic [7:0] e);
        @(posedge mclk);
        any_irq <= i;
        wake_irq <= w;
        irq_enabled <= e;
    endtask : raise
endmodule : cpm_core_model
